// *** verilog/vst_chain.sv ***
// Set-point transfer chain: split range, curve, actuator sense, tuning
`timescale 1ns/1ps
`include "vst_consts.svh"
module vst_chain (
    input  wire logic                    clk_sys,
    input  wire logic                    reset_n,
    input  wire logic                    sw_curve_on,
    input  wire logic                    sw_manual,
    input  wire logic                    sp_valid,
    input  wire logic [9:0]              sp_pct,
    output logic                         sp_ready,
    output logic                         stroke_valid,
    output logic [9:0]                   stroke_pct,
    input  wire logic                    cfg_wr_valid,
    input  wire vst_pkg::vst_cfg_wr_t    cfg_wr,
    output logic                         cfg_reject,
    input  wire logic                    factory_reset,
    output vst_pkg::vst_curve_t          curve_active,
    output logic                         input_type,
    input  wire logic                    tune_start,
    input  wire logic                    tune_fail,
    input  wire logic [15:0]             tune_param,
    output vst_pkg::vst_tune_stat_t      tune_stat,
    output logic                         nvm_store,
    output logic [15:0]                  nvm_data
);
    localparam int unsigned STEP_CYC = `VST_TUNE_STEP_CYC;

    vst_pkg::vst_curve_t      curve_q;
    vst_pkg::vst_dp_state_t   dp_q;
    vst_pkg::vst_tune_state_t ts_q;
    logic [9:0]   node_q [0:20];
    logic [9:0]   lo_q;
    logic [9:0]   hi_q;
    logic         sense_q;
    logic         input_q;
    logic         reject_q;
    logic [9:0]   split_q;
    logic [9:0]   stroke_q;
    logic         valid_q;
    logic         div_start_q;
    logic [19:0]  dividend_q;
    logic         div_done;
    logic [9:0]   div_quo;
    logic [6:0]   prog_q;
    logic [15:0]  step_q;
    logic         fail_q;
    logic         done_q;
    logic         nvm_q;
    logic [15:0]  nvm_data_q;
    logic [9:0]   num;
    logic [209:0] tbl;
    logic         inv;
    logic [9:0]   ix;
    logic [9:0]   iy;
    logic [9:0]   cy;

    function automatic logic [9:0] absdiff(input logic [9:0] a,
                                           input logic [9:0] b);
        absdiff = (a > b) ? 10'(a - b) : 10'(b - a);
    endfunction

    function automatic logic [9:0] flip(input logic [9:0] a);
        flip = 10'(`VST_FULL - a);
    endfunction

    function automatic logic node_ok(input logic [4:0] idx,
                                     input logic [9:0] val);
        logic ok;
        ok = (idx <= `VST_NODE_LAST) && (val <= `VST_FULL);
        if (ok && idx != 5'h00) begin
            ok = absdiff(val, node_q[idx - 5'h01]) <= `VST_MAX_DELTA;
        end
        if (ok && idx < `VST_NODE_LAST) begin
            ok = absdiff(val, node_q[idx + 5'h01]) <= `VST_MAX_DELTA;
        end
        node_ok = ok;
    endfunction

    function automatic logic steps_ok();
        logic ok;
        ok = 1'b1;
        for (int k = 0; k < 20; k++) begin
            if (absdiff(node_q[k], node_q[k + 1]) > `VST_MAX_DELTA) begin
                ok = 1'b0;
            end
        end
        steps_ok = ok;
    endfunction

    // ------------------------------------------------------------
    // Configuration store
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            curve_q  <= vst_pkg::CURVE_LIN;
            lo_q     <= `VST_LO_RST;
            hi_q     <= `VST_HI_RST;
            sense_q  <= `VST_SENSE_RST;
            input_q  <= `VST_INPUT_RST;
            reject_q <= 1'b0;
            for (int k = 0; k <= 20; k++) begin
                node_q[k] <= 10'(k * 50);
            end
        end else if (factory_reset) begin
            curve_q  <= vst_pkg::CURVE_LIN;
            lo_q     <= `VST_LO_RST;
            hi_q     <= `VST_HI_RST;
            sense_q  <= `VST_SENSE_RST;
            input_q  <= `VST_INPUT_RST;
            reject_q <= 1'b0;
            for (int k = 0; k <= 20; k++) begin
                node_q[k] <= 10'(k * 50);
            end
        end else if (cfg_wr_valid) begin
            reject_q <= 1'b0;
            unique case (cfg_wr.kind)
                vst_pkg::CK_CURVE: begin
                    curve_q <= vst_pkg::vst_curve_t'(cfg_wr.value[2:0]);
                end
                vst_pkg::CK_NODE: begin
                    if (node_ok(cfg_wr.index, cfg_wr.value)) begin
                        node_q[cfg_wr.index] <= cfg_wr.value;
                    end else begin
                        reject_q <= 1'b1;
                    end
                end
                vst_pkg::CK_INPUT: begin
                    input_q <= cfg_wr.value[0];
                end
                vst_pkg::CK_SPLIT_LO: begin
                    if (cfg_wr.value <= `VST_LO_MAX && cfg_wr.value < hi_q)
                    begin
                        lo_q <= cfg_wr.value;
                    end else begin
                        reject_q <= 1'b1;
                    end
                end
                vst_pkg::CK_SPLIT_HI: begin
                    if (cfg_wr.value >= `VST_HI_MIN &&
                        cfg_wr.value <= `VST_FULL && cfg_wr.value > lo_q)
                    begin
                        hi_q <= cfg_wr.value;
                    end else begin
                        reject_q <= 1'b1;
                    end
                end
                vst_pkg::CK_SENSE: begin
                    sense_q <= cfg_wr.value[0];
                end
                default: begin
                    reject_q <= 1'b1;
                end
            endcase
        end else begin
            reject_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Curve selection and lookup
    // ------------------------------------------------------------
    always_comb begin
        curve_active = sw_curve_on ? curve_q : vst_pkg::CURVE_LIN;
        inv = 1'b0;
        tbl = `VST_EQ25;
        unique case (curve_active)
            vst_pkg::CURVE_LIN:   tbl = `VST_EQ25;
            vst_pkg::CURVE_EQ25:  tbl = `VST_EQ25;
            vst_pkg::CURVE_EQ33:  tbl = `VST_EQ33;
            vst_pkg::CURVE_EQ50:  tbl = `VST_EQ50;
            vst_pkg::CURVE_INV25: begin
                tbl = `VST_EQ25;
                inv = 1'b1;
            end
            vst_pkg::CURVE_INV33: begin
                tbl = `VST_EQ33;
                inv = 1'b1;
            end
            vst_pkg::CURVE_INV50: begin
                tbl = `VST_EQ50;
                inv = 1'b1;
            end
            vst_pkg::CURVE_FREE: begin
                for (int k = 0; k <= 20; k++) begin
                    tbl[k * 10 +: 10] = node_q[k];
                end
            end
        endcase
        ix = inv ? flip(split_q) : split_q;
        cy = (curve_active == vst_pkg::CURVE_LIN) ? split_q :
             (inv ? flip(iy) : iy);
        if (sp_pct <= lo_q) begin
            num = 10'h000;
        end else if (sp_pct >= hi_q) begin
            num = 10'(hi_q - lo_q);
        end else begin
            num = 10'(sp_pct - lo_q);
        end
    end

    vst_interp u_interp (
        .x     (ix),
        .nodes (tbl),
        .y     (iy)
    );

    vst_divider u_div (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .start    (div_start_q),
        .dividend (dividend_q),
        .divisor  (10'(hi_q - lo_q)),
        .done     (div_done),
        .quotient (div_quo)
    );

    // ------------------------------------------------------------
    // Set-point pipeline
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dp_q        <= vst_pkg::DP_IDLE;
            split_q     <= 10'h000;
            stroke_q    <= 10'h000;
            valid_q     <= 1'b0;
            div_start_q <= 1'b0;
            dividend_q  <= 20'h00000;
        end else begin
            valid_q     <= 1'b0;
            div_start_q <= 1'b0;
            unique case (dp_q)
                vst_pkg::DP_IDLE: begin
                    if (sp_valid) begin
                        dividend_q  <= 20'(num) * 20'(`VST_FULL);
                        div_start_q <= 1'b1;
                        dp_q        <= vst_pkg::DP_DIV;
                    end
                end
                vst_pkg::DP_DIV: begin
                    if (div_done) begin
                        split_q <= div_quo;
                        dp_q    <= vst_pkg::DP_MAP;
                    end
                end
                vst_pkg::DP_MAP: begin
                    stroke_q <= sense_q ? flip(cy) : cy;
                    valid_q  <= 1'b1;
                    dp_q     <= vst_pkg::DP_IDLE;
                end
                default: begin
                    dp_q <= vst_pkg::DP_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Tuning sequence
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ts_q       <= vst_pkg::TS_IDLE;
            prog_q     <= 7'h00;
            step_q     <= 16'h0000;
            fail_q     <= 1'b0;
            done_q     <= 1'b0;
            nvm_q      <= 1'b0;
            nvm_data_q <= 16'h0000;
        end else begin
            done_q <= 1'b0;
            nvm_q  <= 1'b0;
            unique case (ts_q)
                vst_pkg::TS_IDLE: begin
                    if (tune_start && !sw_manual) begin
                        ts_q   <= vst_pkg::TS_RUN;
                        prog_q <= 7'h00;
                        step_q <= 16'h0000;
                        fail_q <= 1'b0;
                    end
                end
                vst_pkg::TS_RUN: begin
                    if (tune_fail || sw_manual) begin
                        fail_q <= 1'b1;
                        ts_q   <= vst_pkg::TS_IDLE;
                    end else if (step_q == 16'(STEP_CYC - 1)) begin
                        step_q <= 16'h0000;
                        prog_q <= prog_q + 7'h01;
                        if (prog_q == `VST_TUNE_DONE - 7'h01) begin
                            ts_q <= vst_pkg::TS_STORE;
                        end
                    end else begin
                        step_q <= step_q + 16'h0001;
                    end
                end
                vst_pkg::TS_STORE: begin
                    nvm_q      <= 1'b1;
                    nvm_data_q <= tune_param;
                    ts_q       <= vst_pkg::TS_DONE;
                end
                vst_pkg::TS_DONE: begin
                    done_q <= 1'b1;
                    ts_q   <= vst_pkg::TS_IDLE;
                end
            endcase
        end
    end

    assign sp_ready         = (dp_q == vst_pkg::DP_IDLE);
    assign stroke_valid     = valid_q;
    assign stroke_pct       = stroke_q;
    assign cfg_reject       = reject_q;
    assign input_type       = input_q;
    assign nvm_store        = nvm_q;
    assign nvm_data         = nvm_data_q;
    assign tune_stat = '{busy:     (ts_q != vst_pkg::TS_IDLE),
                         done:     done_q,
                         failed:   fail_q,
                         progress: prog_q};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    linear_when_off_a: assert property (
        valid_q && !$past(sw_curve_on) && !$past(sense_q)
        |-> stroke_q == $past(split_q))
        else $error("Switch off did not give linear stroke");

    switch_override_a: assert property (
        !sw_curve_on |-> curve_active == vst_pkg::CURVE_LIN)
        else $error("Software curve active with switch off");

    node_steps_a: assert property (steps_ok())
        else $error("Neighbour nodes differ by more than limit");

    split_bounds_a: assert property (
        lo_q <= `VST_LO_MAX && hi_q >= `VST_HI_MIN &&
        hi_q <= `VST_FULL && lo_q < hi_q)
        else $error("Split bounds out of range");

    factory_restore_a: assert property (
        factory_reset |=> lo_q == `VST_LO_RST && hi_q == `VST_HI_RST &&
        curve_q == vst_pkg::CURVE_LIN && input_q == `VST_INPUT_RST)
        else $error("Factory values not restored");

    tune_auto_a: assert property (
        $rose(ts_q == vst_pkg::TS_RUN) |-> !$past(sw_manual))
        else $error("Tuning started in manual state");

    nvm_after_ok_a: assert property (
        nvm_q |-> $past(prog_q) == `VST_TUNE_DONE && !fail_q
        ##1 done_q)
        else $error("Memory written without good tuning run");

    inverse_sense_a: assert property (
        valid_q && $past(sense_q) |-> stroke_q == flip($past(cy)))
        else $error("Inverse sense not mirrored");
endmodule

// *** verilog/vst_consts.svh ***
// Constants for the set-point transfer chain
`ifndef VST_CONSTS_SVH
`define VST_CONSTS_SVH

// ------------------------------------------------------------
// Percent scale, 0.1 % per step
// ------------------------------------------------------------
`define VST_FULL        10'h3e8
`define VST_NODE_STEP   10'h032
`define VST_NODE_LAST   5'h14
`define VST_MAX_DELTA   10'h0c8
`define VST_LO_MAX      10'h2ee
`define VST_HI_MIN      10'h0fa

// ------------------------------------------------------------
// Factory values
// ------------------------------------------------------------
`define VST_LO_RST      10'h000
`define VST_HI_RST      10'h3e8
`define VST_INPUT_RST   1'b0
`define VST_SENSE_RST   1'b0

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define VST_CLK_NS      4
`define VST_TUNE_STEP_NS 1000
`define VST_TUNE_STEP_CYC \
    ((`VST_TUNE_STEP_NS + `VST_CLK_NS - 1) / `VST_CLK_NS)
`define VST_TUNE_DONE   7'h64
`define VST_DIV_STEPS   5'h14

// ------------------------------------------------------------
// Equal-percentage node tables, node 20 first
// ------------------------------------------------------------
`define VST_EQ25 {10'h3e8, 10'h34d, 10'h2c9, 10'h259, 10'h1fa, \
    10'h1a8, 10'h163, 10'h128, 10'h0f6, 10'h0cb, 10'h0a7, 10'h088, \
    10'h06d, 10'h057, 10'h044, 10'h033, 10'h026, 10'h01a, 10'h010, \
    10'h007, 10'h000}
`define VST_EQ33 {10'h3e8, 10'h342, 10'h2b8, 10'h243, 10'h1e1, \
    10'h18f, 10'h14a, 10'h110, 10'h0df, 10'h0b7, 10'h094, 10'h077, \
    10'h05f, 10'h04b, 10'h03a, 10'h02c, 10'h020, 10'h016, 10'h00d, \
    10'h006, 10'h000}
`define VST_EQ50 {10'h3e8, 10'h333, 10'h29e, 10'h223, 10'h1be, \
    10'h16b, 10'h127, 10'h0ef, 10'h0c1, 10'h09b, 10'h07c, 10'h062, \
    10'h04d, 10'h03c, 10'h02e, 10'h022, 10'h018, 10'h010, 10'h00a, \
    10'h004, 10'h000}

`endif

// *** verilog/vst_pkg.sv ***
// Types for the set-point transfer chain
package vst_pkg;

    typedef enum logic [2:0] {
        CURVE_LIN   = 3'h0,
        CURVE_EQ25  = 3'h1,
        CURVE_EQ33  = 3'h2,
        CURVE_EQ50  = 3'h3,
        CURVE_INV25 = 3'h4,
        CURVE_INV33 = 3'h5,
        CURVE_INV50 = 3'h6,
        CURVE_FREE  = 3'h7
    } vst_curve_t;

    typedef enum logic [2:0] {
        CK_CURVE    = 3'h0,
        CK_NODE     = 3'h1,
        CK_INPUT    = 3'h2,
        CK_SPLIT_LO = 3'h3,
        CK_SPLIT_HI = 3'h4,
        CK_SENSE    = 3'h5
    } vst_cfg_kind_t;

    typedef struct packed {
        vst_cfg_kind_t kind;
        logic [4:0]    index;
        logic [9:0]    value;
    } vst_cfg_wr_t;

    typedef struct packed {
        logic       busy;
        logic       done;
        logic       failed;
        logic [6:0] progress;
    } vst_tune_stat_t;

    typedef enum logic [1:0] {
        TS_IDLE  = 2'h0,
        TS_RUN   = 2'h1,
        TS_STORE = 2'h3,
        TS_DONE  = 2'h2
    } vst_tune_state_t;

    typedef enum logic [1:0] {
        DP_IDLE = 2'h0,
        DP_DIV  = 2'h1,
        DP_MAP  = 2'h3
    } vst_dp_state_t;

endpackage

// *** verilog/vst_divider.sv ***
// Sequential restoring divider for split-range scaling
`timescale 1ns/1ps
`include "vst_consts.svh"
module vst_divider (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        start,
    input  wire logic [19:0] dividend,
    input  wire logic [9:0]  divisor,
    output logic             done,
    output logic [9:0]       quotient
);
    logic [19:0] quo_q;
    logic [19:0] dvd_q;
    logic [9:0]  rem_q;
    logic [9:0]  dsr_q;
    logic [4:0]  cnt_q;
    logic        done_q;
    logic [10:0] trial;

    assign trial    = {rem_q, quo_q[19]};
    assign done     = done_q;
    assign quotient = quo_q[9:0];

    // ------------------------------------------------------------
    // Shift and subtract
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            quo_q  <= 20'h00000;
            dvd_q  <= 20'h00000;
            rem_q  <= 10'h000;
            dsr_q  <= 10'h001;
            cnt_q  <= 5'h00;
            done_q <= 1'b0;
        end else if (start) begin
            quo_q  <= dividend;
            dvd_q  <= dividend;
            rem_q  <= 10'h000;
            dsr_q  <= divisor;
            cnt_q  <= `VST_DIV_STEPS;
            done_q <= 1'b0;
        end else if (cnt_q != 5'h00) begin
            if (trial >= {1'b0, dsr_q}) begin
                rem_q <= 10'(trial - {1'b0, dsr_q});
                quo_q <= {quo_q[18:0], 1'b1};
            end else begin
                rem_q <= trial[9:0];
                quo_q <= {quo_q[18:0], 1'b0};
            end
            cnt_q  <= cnt_q - 5'h01;
            done_q <= (cnt_q == 5'h01);
        end else begin
            done_q <= 1'b0;
        end
    end

    div_exact_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        done_q |-> (30'(quo_q) * 30'(dsr_q) <= 30'(dvd_q)) &&
                   (30'(dvd_q) < (30'(quo_q) + 30'h1) * 30'(dsr_q)))
        else $error("Split scaling quotient wrong");
endmodule

// *** verilog/vst_interp.sv ***
// Linear interpolation over a 21-node curve
`timescale 1ns/1ps
`include "vst_consts.svh"
module vst_interp (
    input  wire logic [9:0]   x,
    input  wire logic [209:0] nodes,
    output logic [9:0]        y
);
    logic [4:0]         seg;
    logic [9:0]         frac;
    logic signed [10:0] y0;
    logic signed [10:0] y1;
    logic signed [17:0] prod;
    logic signed [17:0] step;

    // ------------------------------------------------------------
    // Segment pick and blend
    // ------------------------------------------------------------
    always_comb begin
        seg = 5'(x / `VST_NODE_STEP);
        if (seg >= `VST_NODE_LAST) begin
            seg = `VST_NODE_LAST - 5'h01;
        end
        frac = 10'(x - 10'(seg * `VST_NODE_STEP));
        y0   = signed'({1'b0, nodes[seg * 10 +: 10]});
        y1   = signed'({1'b0, nodes[(seg + 5'h01) * 10 +: 10]});
        prod = 18'(y1 - y0) * signed'({8'h00, frac});
        step = prod / signed'({8'h00, `VST_NODE_STEP});
        y    = 10'(18'(y0) + step);
    end
endmodule

// *** verification/vst_far.sv ***
// Far-side model: tuned value and failure report of the actuator
`timescale 1ns/1ps
module vst_far (
    input  wire logic   clk_sys,
    input  wire logic   reset_n,
    input  wire logic   fail_req,
    output logic        tune_fail,
    output logic [15:0] tune_param
);
    assign tune_param = 16'h5a3c;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tune_fail <= 1'b0;
        end else begin
            tune_fail <= fail_req;
        end
    end
endmodule

// *** verification/vst_chain_test.sv ***
// Self-checking bench for the set-point transfer chain
`timescale 1ns/1ps
module vst_chain_test;
    logic                 clk_sys = 1'b0;
    logic                 reset_n = 1'b0;
    logic                 sw_curve_on = 1'b0;
    logic                 sw_manual = 1'b0;
    logic                 sp_valid = 1'b0;
    logic [9:0]           sp_pct = 10'h000;
    logic                 cfg_wr_valid = 1'b0;
    vst_pkg::vst_cfg_wr_t cfg_wr = '0;
    logic                 factory_reset = 1'b0;
    logic                 tune_start = 1'b0;
    logic                 fail_req = 1'b0;
    logic                 sp_ready, stroke_valid, cfg_reject, input_type;
    logic                 nvm_store, tune_fail;
    logic [9:0]           stroke_pct;
    logic [15:0]          nvm_data, tune_param;
    vst_pkg::vst_curve_t  curve_active;
    vst_pkg::vst_tune_stat_t tune_stat;
    int                   n_fail = 0;
    int                   n_compared = 0;
    int                   cyc = 0;
    int                   n;
    initial forever #2 clk_sys = ~clk_sys;
    vst_far far_u (.clk_sys(clk_sys), .reset_n(reset_n), .fail_req(fail_req),
        .tune_fail(tune_fail), .tune_param(tune_param));
    vst_chain dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
        .sw_curve_on(sw_curve_on), .sw_manual(sw_manual),
        .sp_valid(sp_valid), .sp_pct(sp_pct), .sp_ready(sp_ready),
        .stroke_valid(stroke_valid), .stroke_pct(stroke_pct),
        .cfg_wr_valid(cfg_wr_valid), .cfg_wr(cfg_wr),
        .cfg_reject(cfg_reject), .factory_reset(factory_reset),
        .curve_active(curve_active), .input_type(input_type),
        .tune_start(tune_start), .tune_fail(tune_fail),
        .tune_param(tune_param), .tune_stat(tune_stat),
        .nvm_store(nvm_store), .nvm_data(nvm_data));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic finish_test;
        if (n_fail == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cfg(input vst_pkg::vst_cfg_kind_t k, input logic [4:0] i,
                       input logic [9:0] v, input logic rej);
        @(posedge clk_sys);
        cfg_wr_valid <= 1'b1;
        cfg_wr <= '{kind: k, index: i, value: v};
        @(posedge clk_sys);
        cfg_wr_valid <= 1'b0;
        #1 chk(cfg_reject, rej);
    endtask
    task automatic sp(input logic [9:0] v, input logic [9:0] e);
        @(posedge clk_sys);
        sp_valid <= 1'b1;
        sp_pct <= v;
        @(posedge clk_sys);
        sp_valid <= 1'b0;
        n = 0;
        #1 chk(sp_ready, 1'b0);
        while (stroke_valid !== 1'b1 && n < 40) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk(stroke_valid, 1'b1);
        chk(stroke_pct, e);
    endtask
    task automatic start_tune;
        @(posedge clk_sys);
        tune_start <= 1'b1;
        @(posedge clk_sys);
        tune_start <= 1'b0;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            finish_test;
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        #1 chk(input_type, 1'b0);
        chk(curve_active, vst_pkg::CURVE_LIN);
        sp(10'h1f4, 10'h1f4);
        cfg(vst_pkg::CK_SPLIT_LO, 5'h00, 10'h2ef, 1'b1);
        cfg(vst_pkg::CK_SPLIT_HI, 5'h00, 10'h0f9, 1'b1);
        cfg(vst_pkg::CK_SPLIT_LO, 5'h00, 10'h0fa, 1'b0);
        cfg(vst_pkg::CK_SPLIT_HI, 5'h00, 10'h2ee, 1'b0);
        sp(10'h177, 10'h0fa);
        sp(10'h064, 10'h000);
        sp(10'h384, 10'h3e8);
        cfg(vst_pkg::CK_SPLIT_LO, 5'h00, 10'h000, 1'b0);
        cfg(vst_pkg::CK_SPLIT_HI, 5'h00, 10'h3e8, 1'b0);
        cfg(vst_pkg::CK_CURVE, 5'h00, 10'h001, 1'b0);
        sp(10'h1f4, 10'h1f4);
        @(posedge clk_sys) sw_curve_on <= 1'b1;
        sp(10'h1f4, 10'h0a7);
        cfg(vst_pkg::CK_CURVE, 5'h00, 10'h004, 1'b0);
        sp(10'h1f4, 10'h341);
        cfg(vst_pkg::CK_NODE, 5'h01, 10'h12c, 1'b1);
        cfg(vst_pkg::CK_NODE, 5'h01, 10'h0c8, 1'b0);
        cfg(vst_pkg::CK_CURVE, 5'h00, 10'h007, 1'b0);
        sp(10'h019, 10'h064);
        cfg(vst_pkg::CK_SENSE, 5'h00, 10'h001, 1'b0);
        sp(10'h019, 10'h384);
        cfg(vst_pkg::CK_INPUT, 5'h00, 10'h001, 1'b0);
        chk(input_type, 1'b1);
        @(posedge clk_sys) factory_reset <= 1'b1;
        @(posedge clk_sys) factory_reset <= 1'b0;
        #1 chk(input_type, 1'b0);
        sp(10'h019, 10'h019);
        // Manual state refuses the run
        @(posedge clk_sys) sw_manual <= 1'b1;
        start_tune;
        repeat (2) @(posedge clk_sys);
        #1 chk(tune_stat.busy, 1'b0);
        @(posedge clk_sys) sw_manual <= 1'b0;
        start_tune;
        n = 0;
        while (nvm_store !== 1'b1 && n < 26000) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk(nvm_data, 16'h5a3c);
        @(posedge clk_sys);
        #1 chk(tune_stat.done, 1'b1);
        chk(tune_stat.progress, 7'h64);
        repeat (3) @(posedge clk_sys);
        start_tune;
        repeat (20) @(posedge clk_sys);
        fail_req <= 1'b1;
        @(posedge clk_sys) fail_req <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 chk(tune_stat.failed, 1'b1);
        chk(tune_stat.busy, 1'b0);
        finish_test;
    end
endmodule
